// ### fspc_regs.vh
// fspc_regs.vh: constants of the flash self-programming control block.
// assumes inclusion by fspc_flash_self_program_control.v only.
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH

// ==========================================
// control and status register bit positions
`define FSPC_BIT_STORE_EN      0
`define FSPC_BIT_PAGE_ERASE    1
`define FSPC_BIT_PAGE_WRITE    2
`define FSPC_BIT_LOCK_SET      3
`define FSPC_BIT_RWW_REEN      4
`define FSPC_BIT_SIG_READ      5
`define FSPC_BIT_RWW_BUSY      6
`define FSPC_CSR_RESET         8'h00

// ==========================================
// legal lower-five-bit write patterns
`define FSPC_PAT_RWW_REEN      5'h11
`define FSPC_PAT_LOCK_SET      5'h09
`define FSPC_PAT_PAGE_WRITE    5'h05
`define FSPC_PAT_PAGE_ERASE    5'h03
`define FSPC_PAT_BUF_LOAD      5'h01

// ==========================================
// arming windows in cpu cycles
`define FSPC_STORE_WINDOW      3'd4
`define FSPC_LOAD_WINDOW       3'd3

// ==========================================
// signature row pointer addresses
`define FSPC_SIG_ADDR_ID1      16'h0000
`define FSPC_SIG_ADDR_CAL3V    16'h0001
`define FSPC_SIG_ADDR_ID2      16'h0002
`define FSPC_SIG_ADDR_CAL5V    16'h0003
`define FSPC_SIG_ADDR_ID3      16'h0004

// ==========================================
// flash operation time, microseconds, and clock rate in khz
`define FSPC_PROG_MIN_US       3700
`define FSPC_PROG_MAX_US       4500
`define FSPC_CLK_KHZ           25000

`endif

// ### fspc_flash_self_program_control.v
// fspc_flash_self_program_control.v: flash self-programming sequencer.
// assumes a cpu core on clk_i that gives one-cycle write and instruction strobes
// and a flash array that acts on one-cycle command pulses.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.vh"

module fspc_flash_self_program_control #(
  parameter integer ADDR_W       = 16,
  parameter integer PAGE_SHIFT   = 7,
  parameter [15:0]  NO_READ_WHILE_WRITE_SECTION_START   = 16'h3800,
  parameter integer PROG_CYCLES  = ((`FSPC_PROG_MIN_US + `FSPC_PROG_MAX_US) / 2) * (`FSPC_CLK_KHZ / 1000),
  parameter [7:0]   SIG_BYTE1    = 8'h1E,  // arbitrary identification value
  parameter [7:0]   SIG_BYTE2    = 8'h55,  // arbitrary identification value
  parameter [7:0]   SIG_BYTE3    = 8'hAA   // arbitrary identification value
) (
  input  wire              clk_i,
  input  wire              rst_n_i,
  input  wire              por_n_i,
  input  wire              csr_wr_i,
  input  wire [7:0]        csr_wdata_i,
  output reg  [7:0]        csr_rdata_o,
  input  wire              store_instr_i,
  input  wire              load_instr_i,
  input  wire [ADDR_W-1:0] pointer_i,
  input  wire [7:0]        low_work_register_i,
  input  wire [7:0]        high_work_register_i,
  input  wire [7:0]        lock_bits_i,
  input  wire [7:0]        fuse_bits_i,
  input  wire [7:0]        cal_3v_i,
  input  wire [7:0]        cal_5v_i,
  output reg               load_override_o,
  output reg  [7:0]        load_data_o,
  output reg               cpu_halt_o,
  output reg               buf_load_o,
  output reg  [ADDR_W-1:0] buf_addr_o,
  output reg  [15:0]       buf_data_o,
  output reg               page_erase_o,
  output reg               page_write_o,
  output reg               lock_write_o,
  output reg  [7:0]        lock_data_o,
  output reg  [ADDR_W-1:0] page_addr_o,
  output reg               flash_busy_o,
  output reg               rww_reenable_o
);

  // ==========================================
  // states
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_ARMED = 2'd1;
  localparam [1:0] ST_BUSY  = 2'd2;

  localparam [2:0] OP_NONE  = 3'd0;
  localparam [2:0] OP_BUF   = 3'd1;
  localparam [2:0] OP_ERASE = 3'd2;
  localparam [2:0] OP_WRITE = 3'd3;
  localparam [2:0] OP_LOCK  = 3'd4;
  localparam [2:0] OP_SIG   = 3'd5;
  localparam [2:0] OP_RWW   = 3'd6;

  // ==========================================
  // functions
  function [2:0] fspc_decode;
    input [7:0] wd;
    begin
      case (wd[4:0])
        `FSPC_PAT_BUF_LOAD:   fspc_decode = wd[`FSPC_BIT_SIG_READ] ? OP_SIG : OP_BUF;
        `FSPC_PAT_PAGE_ERASE: fspc_decode = OP_ERASE;
        `FSPC_PAT_PAGE_WRITE: fspc_decode = OP_WRITE;
        `FSPC_PAT_LOCK_SET:   fspc_decode = OP_LOCK;
        `FSPC_PAT_RWW_REEN:   fspc_decode = OP_RWW;
        default:              fspc_decode = OP_NONE;
      endcase
    end
  endfunction

  function [7:0] fspc_sig_byte;
    input [ADDR_W-1:0] a;
    begin
      case (a[15:0])
        `FSPC_SIG_ADDR_ID1:   fspc_sig_byte = SIG_BYTE1;
        `FSPC_SIG_ADDR_ID2:   fspc_sig_byte = SIG_BYTE2;
        `FSPC_SIG_ADDR_ID3:   fspc_sig_byte = SIG_BYTE3;
        `FSPC_SIG_ADDR_CAL3V: fspc_sig_byte = cal_3v_i;
        `FSPC_SIG_ADDR_CAL5V: fspc_sig_byte = cal_5v_i;
        default:              fspc_sig_byte = 8'h00;
      endcase
    end
  endfunction

  function fspc_is_page_op;
    input [2:0] o;
    begin
      fspc_is_page_op = (o == OP_ERASE) || (o == OP_WRITE);
    end
  endfunction

  function fspc_is_flash_op;
    input [2:0] o;
    begin
      fspc_is_flash_op = fspc_is_page_op(o) || (o == OP_LOCK);
    end
  endfunction

  function [ADDR_W-1:0] fspc_page_base;
    input [ADDR_W-1:0] a;
    begin
      fspc_page_base = {a[ADDR_W-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
    end
  endfunction

  // ==========================================
  // state
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [2:0]  op_reg;
  reg [2:0]  op_next;
  reg [2:0]  win_reg;
  reg [2:0]  win_next;
  reg [23:0] prog_cnt_reg;
  reg [23:0] prog_cnt_next;
  reg        halt_next;
  reg        cur_busy_reg;
  reg        rst_n_meta_reg;
  reg        rst_n_sync_reg;
  reg        por_n_meta_reg;
  reg        por_n_sync_reg;

  wire [2:0] wr_op       = fspc_decode(csr_wdata_i);
  wire       is_load_op  = (op_reg == OP_SIG) || (op_reg == OP_LOCK);
  wire       in_no_read_while_write_section     = (pointer_i[15:0] >= NO_READ_WHILE_WRITE_SECTION_START);
  wire       prog_done   = (state_reg == ST_BUSY) && (prog_cnt_reg == 24'h000001);
  wire       arm_wr      = csr_wr_i && (wr_op != OP_NONE) && (state_reg != ST_BUSY) && !cur_busy_reg;
  wire       store_hit   = (state_reg == ST_ARMED) && store_instr_i && (op_reg != OP_SIG);
  wire       load_hit    = (state_reg == ST_ARMED) && load_instr_i && is_load_op
                           && (win_reg < `FSPC_LOAD_WINDOW);

  // ==========================================
  // sequencer
  always @* begin
    state_next    = state_reg;
    op_next       = op_reg;
    win_next      = win_reg;
    prog_cnt_next = prog_cnt_reg;
    halt_next     = cpu_halt_o;
    case (state_reg)
      ST_IDLE: begin
        if (arm_wr) begin
          state_next = ST_ARMED;
          op_next    = wr_op;
          win_next   = 3'd0;
        end
      end
      ST_ARMED: begin
        win_next = win_reg + 3'd1;
        if (arm_wr) begin
          op_next  = wr_op;
          win_next = 3'd0;
        end else if (store_hit && fspc_is_flash_op(op_reg)) begin
          state_next    = ST_BUSY;
          prog_cnt_next = PROG_CYCLES[23:0];
          halt_next     = in_no_read_while_write_section && fspc_is_page_op(op_reg);
        end else if (store_hit || load_hit) begin
          state_next = ST_IDLE;
          op_next    = OP_NONE;
        end else if ((op_reg == OP_SIG && win_reg == `FSPC_LOAD_WINDOW - 3'd1) ||
                     win_reg == `FSPC_STORE_WINDOW - 3'd1) begin
          state_next = ST_IDLE;
          op_next    = OP_NONE;
        end
      end
      ST_BUSY: begin
        prog_cnt_next = prog_cnt_reg - 24'd1;
        if (prog_done) begin
          state_next = ST_IDLE;
          op_next    = OP_NONE;
          halt_next  = 1'b0;
        end
      end
      default: begin
        state_next = ST_IDLE;
        op_next    = OP_NONE;
      end
    endcase
  end

  // ==========================================
  // reset release synchronisers
  // assertion stays asynchronous; release is retimed so no flop sees it near an edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_n_meta_reg <= 1'b0;
      rst_n_sync_reg <= 1'b0;
    end else begin
      rst_n_meta_reg <= 1'b1;
      rst_n_sync_reg <= rst_n_meta_reg;
    end
  end

  always @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      por_n_meta_reg <= 1'b0;
      por_n_sync_reg <= 1'b0;
    end else begin
      por_n_meta_reg <= 1'b1;
      por_n_sync_reg <= por_n_meta_reg;
    end
  end

  // flash timing survives cpu reset; only power-on reset aborts it
  always @(posedge clk_i or negedge por_n_sync_reg) begin
    if (!por_n_sync_reg) begin
      prog_cnt_reg <= 24'h000000;
      cur_busy_reg <= 1'b0;
    end else begin
      prog_cnt_reg <= (state_reg == ST_BUSY || cur_busy_reg) && !prog_done && prog_cnt_reg != 24'h0
                      ? prog_cnt_reg - 24'd1 : prog_cnt_next;
      cur_busy_reg <= (prog_cnt_next != 24'h0) && (prog_cnt_reg != 24'h000001);
    end
  end

  always @(posedge clk_i or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_NONE;
      win_reg   <= 3'd0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      win_reg   <= win_next;
    end
  end

  // ==========================================
  // status and halt
  // bit 6 follows the same busy term as flash_busy_o, so status and port agree
  wire busy_next = cur_busy_reg || (state_next == ST_BUSY);

  always @(posedge clk_i or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      csr_rdata_o  <= `FSPC_CSR_RESET;
      cpu_halt_o   <= 1'b0;
      flash_busy_o <= 1'b0;
    end else begin
      csr_rdata_o <= 8'h00;
      csr_rdata_o[`FSPC_BIT_STORE_EN]   <= (state_next != ST_IDLE);
      csr_rdata_o[`FSPC_BIT_PAGE_ERASE] <= (op_next == OP_ERASE);
      csr_rdata_o[`FSPC_BIT_PAGE_WRITE] <= (op_next == OP_WRITE);
      csr_rdata_o[`FSPC_BIT_LOCK_SET]   <= (op_next == OP_LOCK);
      csr_rdata_o[`FSPC_BIT_RWW_REEN]   <= (op_next == OP_RWW);
      csr_rdata_o[`FSPC_BIT_SIG_READ]   <= (op_next == OP_SIG);
      csr_rdata_o[`FSPC_BIT_RWW_BUSY]   <= busy_next;
      cpu_halt_o   <= halt_next;
      flash_busy_o <= busy_next;
    end
  end

  // ==========================================
  // load override path
  always @(posedge clk_i or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      load_override_o <= 1'b0;
      load_data_o     <= 8'h00;
    end else begin
      load_override_o <= load_hit;
      if (load_hit)
        load_data_o <= (op_reg == OP_SIG) ? fspc_sig_byte(pointer_i)
                     : (pointer_i[0] ? fuse_bits_i : lock_bits_i);
    end
  end

  // ==========================================
  // temporary buffer load
  always @(posedge clk_i or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      buf_load_o <= 1'b0;
      buf_addr_o <= {ADDR_W{1'b0}};
      buf_data_o <= 16'h0000;
    end else begin
      buf_load_o <= store_hit && (op_reg == OP_BUF);
      if (store_hit && op_reg == OP_BUF) begin
        buf_addr_o <= {pointer_i[ADDR_W-1:1], 1'b0};
        buf_data_o <= {high_work_register_i, low_work_register_i};
      end
    end
  end

  // ==========================================
  // flash command pulses
  // one pulse per accepted erase, write, lock or rww store, none for buffer loads; erase and write carry page_addr_o, lock carries lock_data_o
  always @(posedge clk_i or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      page_erase_o   <= 1'b0;
      page_write_o   <= 1'b0;
      lock_write_o   <= 1'b0;
      lock_data_o    <= 8'h00;
      page_addr_o    <= {ADDR_W{1'b0}};
      rww_reenable_o <= 1'b0;
    end else begin
      page_erase_o   <= 1'b0;
      page_write_o   <= 1'b0;
      lock_write_o   <= 1'b0;
      rww_reenable_o <= 1'b0;
      if (store_hit) begin
        case (op_reg)
          OP_ERASE: begin
            page_erase_o <= 1'b1;
            page_addr_o  <= fspc_page_base(pointer_i);
          end
          OP_WRITE: begin
            page_write_o <= 1'b1;
            page_addr_o  <= fspc_page_base(pointer_i);
          end
          OP_LOCK: begin
            lock_write_o <= 1'b1;
            lock_data_o  <= low_work_register_i;
          end
          OP_RWW: begin
            rww_reenable_o <= 1'b1;
          end
          default: begin
            page_erase_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // fspc_flash_self_program_control
`default_nettype wire

// ### fspc_chk_asserts.sv
// checker: port timing of the flash self-programming sequencer
// assumes one clock domain; bound onto the sequencer module by the bind below
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port relations
module fspc_chk #(parameter integer PROG_CYCLES = 20, parameter [15:0] NO_READ_WHILE_WRITE_SECTION_START = 16'h3800,
  parameter [7:0] SIG_BYTE1 = 8'h1E) (
  input wire logic        clk_i, rst_n_i, por_n_i, csr_wr_i, store_instr_i, load_instr_i,
  input wire logic [7:0]  csr_wdata_i, csr_rdata_o, low_work_register_i, high_work_register_i,
  input wire logic [7:0]  cal_5v_i, load_data_o, lock_data_o,
  input wire logic [15:0] pointer_i, buf_addr_o, buf_data_o,
  input wire logic        load_override_o, cpu_halt_o, buf_load_o, page_erase_o, page_write_o,
  input wire logic        lock_write_o, flash_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [7:0] c = csr_rdata_o;
  wire       idle = !flash_busy_o;
  logic [15:0] blen_reg;
  // held through cpu reset: the flash timer keeps running then
  always @(posedge clk_i or negedge por_n_i)
    if (!por_n_i) blen_reg <= 16'h0000;
    else if (rst_n_i) blen_reg <= flash_busy_o ? blen_reg + 16'h0001 : 16'h0000;
  property p_erase; store_instr_i && idle && c[2:0] == 3'h3 |=> page_erase_o; endproperty
  a_erase: assert property (p_erase) else $error("erase pulse missing");
  property p_write; store_instr_i && idle && c[2:0] == 3'h5 |=> page_write_o && !page_erase_o; endproperty
  a_write: assert property (p_write) else $error("page write pulse missing");
  property p_lock; store_instr_i && idle && c[3:0] == 4'h9 |=>
    lock_write_o && lock_data_o == $past(low_work_register_i); endproperty
  a_lock: assert property (p_lock) else $error("lock write wrong");
  property p_buf; store_instr_i && idle && c[5:0] == 6'h01 |=> buf_load_o && !buf_addr_o[0] &&
    buf_data_o == {$past(high_work_register_i), $past(low_work_register_i)}; endproperty
  a_buf: assert property (p_buf) else $error("buffer load wrong");
  property p_sig; load_instr_i && c[5] && c[0] && pointer_i == 16'h0000 |=>
    load_override_o && load_data_o == SIG_BYTE1; endproperty
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  property p_cal; load_instr_i && c[5] && c[0] && pointer_i == 16'h0003 |=>
    load_override_o && load_data_o == $past(cal_5v_i); endproperty
  a_cal: assert property (p_cal) else $error("calibration byte wrong");
  property p_clr; csr_wr_i && idle ##1 !(csr_wr_i || store_instr_i || load_instr_i) [*4] |=>
    c[5:0] == 6'h00; endproperty
  a_clr: assert property (p_clr) else $error("armed bits outlive window");
  property p_bad; csr_wr_i && idle && c[5:0] == 6'h00 &&
    !(csr_wdata_i[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) |=> c[5:0] == 6'h00; endproperty
  a_bad: assert property (p_bad) else $error("illegal pattern took effect");
  property p_halt; store_instr_i && idle && c[0] && (c[1] ^ c[2]) && pointer_i >= NO_READ_WHILE_WRITE_SECTION_START |=>
    cpu_halt_o [*2]; endproperty
  a_halt: assert property (p_halt) else $error("core not halted");
  property p_hold; cpu_halt_o |-> c[0] && (c[1] || c[2]); endproperty
  a_hold: assert property (p_hold) else $error("halt outside erase or write");
  property p_dur; flash_busy_o |-> blen_reg <= PROG_CYCLES; endproperty
  a_dur: assert property (p_dur) else $error("flash busy too long");
endmodule // fspc_chk
bind fspc_flash_self_program_control fspc_chk #(.PROG_CYCLES(PROG_CYCLES), .NO_READ_WHILE_WRITE_SECTION_START(NO_READ_WHILE_WRITE_SECTION_START),
  .SIG_BYTE1(SIG_BYTE1)) i_fspc_chk (.*);
`default_nettype wire

// ### fspc_cpu.sv
// cpu core model: register writes and store/load instruction strobes
// assumes calls at a falling edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module fspc_cpu (
  input  wire logic        clk_i,
  input  wire logic        halt_i,
  output logic             csr_wr_o = 1'b0,
  output logic [7:0]       csr_wdata_o = 8'h00,
  output logic             st_o = 1'b0,
  output logic             ld_o = 1'b0,
  output logic [15:0]      ptr_o = 16'h0000,
  output logic [7:0]       hi_o = 8'h00,
  output logic [7:0]       lo_o = 8'h00
);
  // ==========================================
  // one instruction per call, one cycle long; idle lines show inverted data
  task automatic wr(input logic [7:0] d);
    csr_wdata_o = d;
    csr_wr_o = 1'b1;
    @(negedge clk_i);
    csr_wr_o = 1'b0;
    csr_wdata_o = ~d;
  endtask
  task automatic op(input logic s, input logic [15:0] p, input logic [7:0] h, input logic [7:0] l);
    while (halt_i) @(negedge clk_i);
    {st_o, ld_o, ptr_o, hi_o, lo_o} = {s, !s, p, h, l};
    @(negedge clk_i);
    {st_o, ld_o, ptr_o, hi_o, lo_o} = {2'b00, ~p, ~h, ~l};
  endtask
endmodule // fspc_cpu
`default_nettype wire

// ### tb_top.sv
// testbench: cpu model drives the sequencer, monitor checks result pulses
// assumes the design files and the checker compiled before
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  localparam integer PC = 20;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, por_n_i = 1'b0;
  logic [7:0]  lock_b = 8'h00, fuse_b = 8'h00, c3v = 8'h00, c5v = 8'h00, a, b;
  logic [7:0]  sv[5], bad[5] = '{8'h07, 8'h1F, 8'h02, 8'h10, 8'h19};
  logic [15:0] p;
  logic [47:0] q[$], exp_v, got_v;
  wire         wr, st, ld, ovr, halt, bl, pe, pw, lw, busy, rww;
  wire [7:0]   wd, hi, lo, csr, ldat, ldd;
  wire [15:0]  ptr, bdat, baddr, paddr;
  int          err_total = 0, samples_checked = 0, n;
  fspc_flash_self_program_control #(.PROG_CYCLES(PC), .SIG_BYTE1(8'h5A), .SIG_BYTE2(8'hC3),
    .SIG_BYTE3(8'h0F)) i_fspc_flash_self_program_control (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .por_n_i(por_n_i), .csr_wr_i(wr), .csr_wdata_i(wd), .csr_rdata_o(csr), .store_instr_i(st),
    .load_instr_i(ld), .pointer_i(ptr), .low_work_register_i(lo), .high_work_register_i(hi),
    .lock_bits_i(lock_b), .fuse_bits_i(fuse_b), .cal_3v_i(c3v), .cal_5v_i(c5v),
    .load_override_o(ovr), .load_data_o(ldat), .cpu_halt_o(halt), .buf_load_o(bl),
    .buf_addr_o(baddr), .buf_data_o(bdat), .page_erase_o(pe), .page_write_o(pw), .lock_write_o(lw),
    .lock_data_o(ldd), .page_addr_o(paddr), .flash_busy_o(busy), .rww_reenable_o(rww));
  fspc_cpu i_fspc_cpu (.clk_i(clk_i), .halt_i(halt), .csr_wr_o(wr), .csr_wdata_o(wd), .st_o(st),
    .ld_o(ld), .ptr_o(ptr), .hi_o(hi), .lo_o(lo));
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [47:0] ex(input logic [5:0] k, input logic [23:0] d,
                                     input logic [15:0] ad = 16'h0000);
    return {2'h0, k, ad, d};
  endfunction
  task automatic idle(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic waitb;
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 200) err_total++;
  endtask
  task automatic conclude;
    `CHK(q.size(), 0)
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // monitor: every result pulse must match the oldest note
  always @(negedge clk_i) if (ovr | bl | pe | pw | lw | rww) begin
    exp_v = q.size() ? q.pop_front() : 48'hFFFFFFFFFFFF;
    got_v = {2'h0, rww, ovr, bl, pe, pw, lw, bl ? baddr : (pe | pw) ? paddr : 16'h0000,
      ovr ? {16'h0000, ldat} : bl ? {8'h00, bdat} : lw ? {16'h0000, ldd} : 24'h000000};
    `CHK(got_v, exp_v)
  end
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    {lock_b, fuse_b, c3v, c5v} = $urandom(2);
    sv = '{8'h5A, c3v, 8'hC3, c5v, 8'h0F};
    idle(10);
    {rst_n_i, por_n_i} = 2'b11;
    idle(3);
    for (int k = 0; k < 6; k++) begin
      {a, b, p} = $urandom;
      i_fspc_cpu.wr(8'h01);
      `CHK(csr, 8'h01)
      idle(k);
      if (k < 4) q.push_back(ex(5'h08, {8'h00, a, b}, {p[15:1], 1'b0}));
      i_fspc_cpu.op(1'b1, p, a, b);
      `CHK(csr, 8'h00)
    end
    i_fspc_cpu.wr(8'h01);
    idle(3);
    i_fspc_cpu.wr(8'h01);
    idle(3);
    q.push_back(ex(5'h08, {8'h00, a, b}, {p[15:1], 1'b0}));
    i_fspc_cpu.op(1'b1, p, a, b);
    i_fspc_cpu.wr(8'h11);
    `CHK(csr, 8'h11)
    q.push_back(ex(6'h20, 24'h000000));
    i_fspc_cpu.op(1'b1, p, a, b);
    foreach (bad[k]) begin
      i_fspc_cpu.wr(bad[k]);
      `CHK(csr[5:0], 6'h00)
      i_fspc_cpu.op(1'b1, p, a, b);
    end
    $display("test buffer and patterns done");
    for (int k = 0; k < 5; k++) begin
      {lock_b, fuse_b, c3v, c5v} = $urandom;
      sv[1] = c3v;
      sv[3] = c5v;
      i_fspc_cpu.wr(8'h21);
      q.push_back(ex(5'h10, {16'h0000, sv[k]}));
      i_fspc_cpu.op(1'b0, 16'(k), a, b);
      `CHK(csr, 8'h00)
    end
    i_fspc_cpu.wr(8'h21);
    idle(3);
    i_fspc_cpu.op(1'b0, 16'h0000, a, b);
    for (int k = 0; k < 2; k++) begin
      {lock_b, fuse_b, c3v, c5v} = $urandom;
      i_fspc_cpu.wr(8'h09);
      q.push_back(ex(5'h10, {16'h0000, k ? fuse_b : lock_b}));
      i_fspc_cpu.op(1'b0, 16'(k), a, b);
    end
    i_fspc_cpu.wr(8'h09);
    q.push_back(ex(5'h01, {16'h0000, b}));
    i_fspc_cpu.op(1'b1, p, a, b);
    waitb();
    `CHK(csr, 8'h00)
    $display("test reads and lock done");
    i_fspc_cpu.wr(8'h03);
    q.push_back(ex(5'h04, 24'h000000, 16'h3900));
    i_fspc_cpu.op(1'b1, 16'h3900, a, b);
    `CHK(csr, 8'h43)
    `CHK(halt, 1'b1)
    waitb();
    `CHK(n >= PC - 2 && n <= PC + 1, 1'b1)
    `CHK({csr, halt}, 9'h000)
    i_fspc_cpu.wr(8'h05);
    q.push_back(ex(5'h02, 24'h000000, 16'h0100));
    i_fspc_cpu.op(1'b1, 16'h0100, a, b);
    `CHK(halt, 1'b0)
    i_fspc_cpu.wr(8'h01);
    `CHK(csr, 8'h45)
    waitb();
    `CHK(csr, 8'h00)
    i_fspc_cpu.wr(8'h03);
    q.push_back(ex(5'h04, 24'h000000, 16'h3900));
    i_fspc_cpu.op(1'b1, 16'h3900, a, b);
    idle(3);
    rst_n_i = 1'b0;
    idle(2);
    rst_n_i = 1'b1;
    idle(3);
    `CHK(busy, 1'b1)
    waitb();
    `CHK(busy, 1'b0)
    i_fspc_cpu.wr(8'h05);
    q.push_back(ex(5'h02, 24'h000000, 16'h0200));
    i_fspc_cpu.op(1'b1, 16'h0200, a, b);
    idle(2);
    {rst_n_i, por_n_i} = 2'b00;
    idle(2);
    {rst_n_i, por_n_i} = 2'b11;
    idle(3);
    `CHK({busy, csr}, 9'h000)
    $display("test erase, write and reset done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
